// ### src/fetch_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "fetch_params.svh"
module fetch_mem
#(
    parameter int               WIDTH = `CTR_W,
    parameter int               DEPTH = `PHT_ENTRIES,
    parameter int               AW    = `PHT_IDX_W,
    parameter logic [WIDTH-1:0] INIT  = '0
)
(
    // Clock and reset.
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Write port.
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Registered read port.
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0]            rd_data;
    } mem_state_type;

    mem_state_type state_reg;
    mem_state_type state_next;

    // Reading returns the old content when the same cell is written.
    always_comb
    begin
        state_next = state_reg;
        state_next.rd_data = state_reg.cells[rd_addr_in];
        if (wr_en_in)
        begin
            state_next.cells[wr_addr_in] = wr_data_in;
        end
    end

    // Reset clears every cell to its initial value.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_reg.cells   <= {DEPTH{INIT}};
            state_reg.rd_data <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rd_data_out = state_reg.rd_data;
endmodule
`default_nettype wire

// ### src/fetch_params.svh
`ifndef FETCH_PARAMS_SVH
`define FETCH_PARAMS_SVH
// What this block does
// [RULE1] Fetch up to four instructions per cycle, deliver up to two to decode.
// [RULE2] Fetch from the instruction cache or memory and predict branches before delivery.
// [RULE3] A four-entry branch target cache predicts targets of indirect branches.
// [RULE4] The branch target cache needs no software flush; wrong targets only cost time.
// [RULE5] Conditional direction comes from global history and a 256-entry pattern table.
// [RULE6] A four-entry hardware return stack receives the return address of each call.
// [RULE7] A recognised return pops the stack top and uses it as predicted target.
// [RULE8] The return stack needs no software flush; wrong returns only cost time.
// [RULE9] The instruction cache is two-way, virtually indexed and physically tagged.
// [RULE10] A cache line holds eight 32-bit or sixteen 16-bit instructions.
// [RULE11] A linefill buffer collects the missing line from memory before the cache write.
// [RULE12] A push onto a full stack drops the oldest; an empty pop predicts nothing.

// Data and instruction widths.
`define XLEN            32
`define INSN_W          32
`define HALF_W          16
// Fetch and delivery widths per cycle.
`define FETCH_WIDTH     4
`define ISSUE_WIDTH     2
// Cache geometry.
`define WAYS            2
`define LINE_WORDS      8
`define LINE_HALFWORDS  16
`define LINE_BITS       256
`define SETS            16
`define IDX_W           4
`define IDX_LSB         5
`define IDX_MSB         8
`define QUAD_BIT        4
`define WORD_LSB        2
`define WORD_MSB        3
`define LINE_OFF_W      5
`define PAGE_LSB        12
`define PAGE_OFF_MSB    11
`define PTAG_W          20
`define TAG_ENTRY_W     21
`define TAG_VALID_BIT   20
// Linefill beats of one word each.
`define BEAT_CNT_W      3
`define LAST_BEAT       3'h7
// Pattern history table.
`define PHT_ENTRIES     256
`define PHT_IDX_W       8
`define PHT_IDX_LSB     2
`define PHT_IDX_MSB     9
`define CTR_W           2
`define CTR_RESET       2'h1
`define CTR_MAX         2'h3
`define CTR_MIN         2'h0
`define CTR_TAKEN_BIT   1
// Branch target cache and return stack.
`define BTC_ENTRIES     4
`define BTC_PTR_W       2
`define RS_ENTRIES      4
`define RS_PTR_W        2
`define RS_CNT_W        3
`define RS_FULL         3'h4
// Instruction class field and displacement.
`define OPC_MSB         31
`define OPC_LSB         28
`define OPC_COND        4'h1
`define OPC_JUMP        4'h2
`define OPC_CALL        4'h3
`define OPC_RETURN      4'h4
`define OPC_INDIRECT    4'h5
`define DISP_MSB        23
`define DISP_SEXT_W     6
// Address steps and reset values.
`define WORD_BYTES      32'h0000_0004
`define QUAD_BYTES      32'h0000_0010
`define RESET_PC        32'h0000_0000
`define LFSR_W          4
`define LFSR_RESET      4'h9
`endif

// ### src/fetch_pkg.sv
`include "fetch_params.svh"
package fetch_pkg;
    typedef logic [`XLEN-1:0]      addr_type;
    typedef logic [`INSN_W-1:0]    insn_type;
    typedef logic [`PHT_IDX_W-1:0] pht_idx_type;
    typedef logic [`CTR_W-1:0]     ctr_type;

    // One instruction handed to decode with its prediction.
    typedef struct packed {
        logic        valid;
        insn_type    insn;
        addr_type    pc;
        logic        pred_taken;
        addr_type    pred_target;
        pht_idx_type pht_idx;
        ctr_type     pht_ctr;
    } slot_type;

    // Outcome of one branch, reported by execute.
    typedef struct packed {
        logic        valid;
        addr_type    pc;
        logic        taken;
        addr_type    target;
        logic        is_cond;
        logic        is_indirect;
        pht_idx_type pht_idx;
        ctr_type     pht_ctr;
    } resolve_type;

    // Pipeline flush with the new fetch address.
    typedef struct packed {
        logic     valid;
        addr_type pc;
    } redirect_type;

    // Linefill request towards memory.
    typedef struct packed {
        logic     req;
        addr_type addr;
    } fill_req_type;

    // Linefill answer from memory.
    typedef struct packed {
        logic     gnt;
        logic     rvalid;
        insn_type rdata;
    } fill_rsp_type;

    typedef enum logic [1:0] {RUN, MISS_REQ, MISS_FILL, MISS_WRITE} fsm_type;
endpackage

// ### src/instruction_fetch_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "fetch_params.svh"
module instruction_fetch_unit
    import fetch_pkg::*;
(
    // Clock and reset.
    input  wire logic                          clk_in,
    input  wire logic                          reset_in,
    // Control from the decode_execute_unit.
    input  wire redirect_type                  redirect_in,
    input  wire resolve_type                   resolve_in,
    input  wire logic                          dec_ready_in,
    // Delivery to the decode_execute_unit.
    output slot_type [`ISSUE_WIDTH-1:0]        issue_out,
    // Address translation for the fetch address.
    output addr_type                           fetch_vaddr_out,
    input  wire logic [`PTAG_W-1:0]            fetch_ptag_in,
    // Linefill port towards memory.
    output fill_req_type                       fill_req_out,
    input  wire fill_rsp_type                  fill_rsp_in
);
    typedef logic [`LINE_WORDS-1:0][`INSN_W-1:0] line_type; // [RULE10]

    typedef struct packed {
        fsm_type                       state;
        addr_type                      pc;
        logic                          rd_valid;
        pht_idx_type                   pht_idx;
        pht_idx_type                   ghr;
        logic [`PTAG_W-1:0]            miss_ptag;
        logic [`BEAT_CNT_W-1:0]        beat;
        line_type                      linefill;
        logic [`LFSR_W-1:0]            lfsr;
        slot_type [`FETCH_WIDTH-1:0]   group;
        slot_type [`ISSUE_WIDTH-1:0]   issue;
        logic [`BTC_ENTRIES-1:0]       btc_valid;
        addr_type [`BTC_ENTRIES-1:0]   btc_tag;
        addr_type [`BTC_ENTRIES-1:0]   btc_target;
        logic [`BTC_PTR_W-1:0]         btc_ptr;
        fill_req_type                  fill_req;
    } fetch_regs_type;

    fetch_regs_type r_reg;
    fetch_regs_type r_next;

    // Cache and predictor array signals.
    logic [`IDX_W-1:0]             rd_index;
    logic [`IDX_W-1:0]             wr_index;
    logic [`WAYS-1:0]              way_wr;
    logic [`TAG_ENTRY_W-1:0]       tag_rd [`WAYS];
    line_type                      data_rd [`WAYS];
    logic [`WAYS-1:0]              way_hit;
    pht_idx_type                   pht_rd_idx;
    ctr_type                       pht_rd;
    logic                          pht_wr;
    ctr_type                       pht_wr_data;
    // Return stack handshake.
    logic                          rs_push;
    addr_type                      rs_push_addr;
    logic                          rs_pop;
    logic                          rs_valid;
    addr_type                      rs_top;

    // Per-way tag and data arrays, indexed by virtual bits.
    genvar w;
    generate
        for (w = 0; w < `WAYS; w++)
        begin : g_way
            fetch_mem #(.WIDTH(`TAG_ENTRY_W), .DEPTH(`SETS), .AW(`IDX_W)) tag_mem
            (
                .clk_in      (clk_in),
                .reset_in    (reset_in),
                .wr_en_in    (way_wr[w]),
                .wr_addr_in  (wr_index),
                .wr_data_in  ({1'b1, r_reg.miss_ptag}),
                .rd_addr_in  (rd_index),
                .rd_data_out (tag_rd[w])
            );
            fetch_mem #(.WIDTH(`LINE_BITS), .DEPTH(`SETS), .AW(`IDX_W)) data_mem
            (
                .clk_in      (clk_in),
                .reset_in    (reset_in),
                .wr_en_in    (way_wr[w]),
                .wr_addr_in  (wr_index),
                .wr_data_in  (r_reg.linefill),
                .rd_addr_in  (rd_index),
                .rd_data_out (data_rd[w])
            );
            // Physical tag compare on the translated page.
            assign way_hit[w] = tag_rd[w][`TAG_VALID_BIT]
                                && (tag_rd[w][`PTAG_W-1:0] == fetch_ptag_in); // [RULE9]
        end
    endgenerate

    // Global pattern history table of two-bit counters.
    fetch_mem #(.WIDTH(`CTR_W), .DEPTH(`PHT_ENTRIES), .AW(`PHT_IDX_W), .INIT(`CTR_RESET)) pht_mem
    (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .wr_en_in    (pht_wr),
        .wr_addr_in  (resolve_in.pht_idx),
        .wr_data_in  (pht_wr_data),
        .rd_addr_in  (pht_rd_idx),
        .rd_data_out (pht_rd)
    );

    // Hardware return stack.
    return_stack rs
    (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .push_in       (rs_push),
        .push_addr_in  (rs_push_addr),
        .pop_in        (rs_pop),
        .top_valid_out (rs_valid),
        .top_addr_out  (rs_top)
    );

    // Fetch, predict, refill and deliver.
    always_comb
    begin
        line_type           line;
        logic               taken_found;
        logic [2:0]         k;
        logic [2:0]         pos;
        addr_type           slot_pc;
        addr_type           target;
        addr_type           next_fetch;
        insn_type           insn;
        logic               pred;
        logic               btc_hit;
        logic [`BTC_PTR_W-1:0] btc_slot;
        line = way_hit[1] ? data_rd[1] : data_rd[0];
        taken_found = 1'b0;
        k = '0;
        pos = '0;
        slot_pc = '0;
        target = '0;
        next_fetch = '0;
        insn = '0;
        pred = 1'b0;
        btc_hit = 1'b0;
        btc_slot = r_reg.btc_ptr;
        r_next = r_reg;
        way_wr = '0;
        wr_index = r_reg.fill_req.addr[`IDX_MSB:`IDX_LSB];
        pht_wr = 1'b0;
        pht_wr_data = resolve_in.pht_ctr;
        rs_push = 1'b0;
        rs_push_addr = '0;
        rs_pop = 1'b0;

        // Decode takes both slots together; at most two leave per cycle.
        if (!r_reg.issue[0].valid || dec_ready_in)
        begin
            r_next.issue[0] = r_reg.group[0];                          // [RULE1]
            r_next.issue[1] = r_reg.group[1];
            r_next.group[0] = r_reg.group[2];
            r_next.group[1] = r_reg.group[3];
            r_next.group[2] = '0;
            r_next.group[3] = '0;
        end

        unique case (r_reg.state)
            RUN:
            begin
                r_next.rd_valid = 1'b1;
                if (r_reg.rd_valid && !r_next.group[0].valid)
                begin
                    if (way_hit != '0)
                    begin
                        // Up to four words from the fetch word to the end of its quad.
                        next_fetch = {r_reg.pc[`XLEN-1:`QUAD_BIT], {`QUAD_BIT{1'b0}}}
                                     + `QUAD_BYTES;
                        for (int i = 0; i < `FETCH_WIDTH; i++)
                        begin
                            pos = {r_reg.pc[`QUAD_BIT], 2'(i)};
                            slot_pc = {r_reg.pc[`XLEN-1:`IDX_LSB], pos, 2'b00};
                            if (2'(i) >= r_reg.pc[`WORD_MSB:`WORD_LSB] && !taken_found)
                            begin
                                insn = line[pos];
                                target = slot_pc + {{`DISP_SEXT_W{insn[`DISP_MSB]}},
                                                    insn[`DISP_MSB:0], 2'b00};
                                pred = 1'b0;
                                unique case (insn[`OPC_MSB:`OPC_LSB])
                                    `OPC_COND:     pred = pht_rd[`CTR_TAKEN_BIT]; // [RULE5]
                                    `OPC_JUMP:     pred = 1'b1;
                                    `OPC_CALL:
                                    begin
                                        pred = 1'b1;
                                        rs_push = 1'b1;                           // [RULE6]
                                        rs_push_addr = slot_pc + `WORD_BYTES;
                                    end
                                    `OPC_RETURN:
                                    begin
                                        pred = rs_valid;                          // [RULE12]
                                        rs_pop = rs_valid;                        // [RULE7]
                                        target = rs_top;
                                    end
                                    `OPC_INDIRECT:
                                    begin
                                        for (int e = 0; e < `BTC_ENTRIES; e++)
                                        begin
                                            if (r_reg.btc_valid[e] && r_reg.btc_tag[e] == slot_pc)
                                            begin
                                                pred = 1'b1;                      // [RULE3]
                                                target = r_reg.btc_target[e];
                                            end
                                        end
                                    end
                                    default:       pred = 1'b0;
                                endcase
                                r_next.group[k[1:0]] = '{valid: 1'b1, insn: insn, pc: slot_pc,
                                    pred_taken: pred, pred_target: pred ? target : '0,
                                    pht_idx: r_reg.pht_idx, pht_ctr: pht_rd};     // [RULE2]
                                k = k + 3'h1;
                                if (pred)
                                begin
                                    taken_found = 1'b1;
                                    next_fetch = target;
                                end
                            end
                        end
                        r_next.pc = next_fetch;
                    end
                    else
                    begin
                        // Miss: request the line at its physical address.
                        r_next.state = MISS_REQ;
                        r_next.rd_valid = 1'b0;
                        r_next.miss_ptag = fetch_ptag_in;
                        r_next.fill_req.req = 1'b1;
                        r_next.fill_req.addr = {fetch_ptag_in, r_reg.pc[`PAGE_OFF_MSB:`IDX_LSB],
                                                {`LINE_OFF_W{1'b0}}};
                    end
                end
            end
            MISS_REQ:
            begin
                r_next.rd_valid = 1'b0;
                if (fill_rsp_in.gnt)
                begin
                    r_next.fill_req.req = 1'b0;
                    r_next.beat = '0;
                    r_next.state = MISS_FILL;
                end
            end
            MISS_FILL:
            begin
                r_next.rd_valid = 1'b0;
                if (fill_rsp_in.rvalid)
                begin
                    r_next.linefill[r_reg.beat] = fill_rsp_in.rdata;      // [RULE11]
                    r_next.beat = r_reg.beat + 1'b1;
                    if (r_reg.beat == `LAST_BEAT)
                    begin
                        r_next.state = MISS_WRITE;
                    end
                end
            end
            MISS_WRITE:
            begin
                // Pseudo-random victim way; the new line is reread next cycle.
                way_wr[r_reg.lfsr[0]] = 1'b1;                             // [RULE11]
                r_next.lfsr = {r_reg.lfsr[`LFSR_W-2:0], r_reg.lfsr[`LFSR_W-1] ^ r_reg.lfsr[`LFSR_W-2]};
                r_next.rd_valid = 1'b0;
                r_next.state = RUN;
            end
        endcase

        // Execute redirect discards everything fetched; a refill still completes.
        if (redirect_in.valid)
        begin
            r_next.pc = redirect_in.pc;
            r_next.group = '0;
            r_next.issue = '0;
            r_next.rd_valid = 1'b0;
            rs_push = 1'b0;
            rs_pop = 1'b0;
            if (r_reg.state == RUN)
            begin
                r_next.state = RUN;
                r_next.fill_req = r_reg.fill_req;
            end
        end

        // Resolved branches train history, counters and target cache.
        if (resolve_in.valid && resolve_in.is_cond)
        begin
            pht_wr = 1'b1;                                                // [RULE5]
            if (resolve_in.taken && resolve_in.pht_ctr != `CTR_MAX)
            begin
                pht_wr_data = resolve_in.pht_ctr + 1'b1;
            end
            else if (!resolve_in.taken && resolve_in.pht_ctr != `CTR_MIN)
            begin
                pht_wr_data = resolve_in.pht_ctr - 1'b1;
            end
            r_next.ghr = {r_reg.ghr[`PHT_IDX_W-2:0], resolve_in.taken};
        end
        if (resolve_in.valid && resolve_in.is_indirect && resolve_in.taken)
        begin
            for (int e = 0; e < `BTC_ENTRIES; e++)
            begin
                if (r_reg.btc_valid[e] && r_reg.btc_tag[e] == resolve_in.pc)
                begin
                    btc_hit = 1'b1;
                    btc_slot = `BTC_PTR_W'(e);
                end
            end
            r_next.btc_valid[btc_slot] = 1'b1;                            // [RULE3]
            r_next.btc_tag[btc_slot] = resolve_in.pc;
            r_next.btc_target[btc_slot] = resolve_in.target;
            if (!btc_hit)
            begin
                r_next.btc_ptr = r_reg.btc_ptr + 1'b1;
            end
        end

        // Arrays are read for the address that will stand in the fetch register.
        rd_index = r_next.pc[`IDX_MSB:`IDX_LSB];                          // [RULE9]
        pht_rd_idx = r_next.pc[`PHT_IDX_MSB:`PHT_IDX_LSB] ^ r_reg.ghr;
        r_next.pht_idx = pht_rd_idx;
    end

    // Target cache has no flush input; stale targets only mispredict.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            r_reg <= '0;                                                  // [RULE4]
            r_reg.pc <= `RESET_PC;
            r_reg.lfsr <= `LFSR_RESET;
            r_reg.state <= RUN;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state register.
    assign issue_out       = r_reg.issue;
    assign fetch_vaddr_out = r_reg.pc;
    assign fill_req_out    = r_reg.fill_req;
endmodule
`default_nettype wire

// ### src/return_stack.sv
`timescale 1ns/1ns
`default_nettype none
`include "fetch_params.svh"
module return_stack
    import fetch_pkg::*;
(
    // Clock and reset.
    input  wire logic     clk_in,
    input  wire logic     reset_in,
    // Push and pop requests.
    input  wire logic     push_in,
    input  wire addr_type push_addr_in,
    input  wire logic     pop_in,
    // Top of stack.
    output logic          top_valid_out,
    output addr_type      top_addr_out
);
    typedef struct packed {
        addr_type [`RS_ENTRIES-1:0] entries;
        logic [`RS_PTR_W-1:0]       ptr;
        logic [`RS_CNT_W-1:0]       count;
    } rs_state_type;

    rs_state_type state_reg;
    rs_state_type state_next;

    // Circular store: a push on a full stack overwrites the oldest entry.
    always_comb
    begin
        state_next = state_reg;
        if (pop_in && state_reg.count != '0)
        begin
            state_next.ptr = state_reg.ptr - 1'b1;                 // [RULE7]
            state_next.count = state_reg.count - 1'b1;
        end
        if (push_in)
        begin
            state_next.entries[state_next.ptr] = push_addr_in;     // [RULE6]
            state_next.ptr = state_next.ptr + 1'b1;
            if (state_next.count != `RS_FULL)
            begin
                state_next.count = state_next.count + 1'b1;        // [RULE12]
            end
        end
    end

    // No flush port exists; stale entries only mispredict.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_reg <= '0;                                       // [RULE8]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // An empty stack offers no prediction.
    assign top_valid_out = (state_reg.count != '0);                // [RULE12]
    assign top_addr_out  = state_reg.entries[state_reg.ptr - 1'b1];
endmodule
`default_nettype wire

// ### verif/exec_model.sv
`timescale 1ns/1ns
`default_nettype none
module exec_model
    import fetch_pkg::*;
(
    // Clock, reset and decode pacing.
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic         slow_in,
    // Linefill and decode handshakes.
    input  wire fill_req_type fill_req_in,
    output fill_rsp_type      fill_rsp_out,
    output logic              dec_ready_out
);
    logic       tick_reg;
    logic       busy_reg;
    logic [2:0] beat_reg;
    addr_type   addr_reg;
    // Program image: a jump, a call and a return among plain words.
    function automatic insn_type word_at(input addr_type a);
        case (a[7:0])
            8'h24:   return 32'h2000_0004;
            8'h34:   return 32'h3000_0003;
            8'h40:   return 32'h4000_0000;
            default: return {4'h0, a[27:0]};
        endcase
    endfunction
    // Decode stalls every other cycle when paced.
    assign dec_ready_out = !slow_in || tick_reg;
    // Grant a cycle late, then eight beats in line order; idle data keeps toggling.
    always_ff @(posedge clk_in)
    begin
        tick_reg <= !reset_in && !tick_reg;
        fill_rsp_out.gnt <= fill_req_in.req && !fill_rsp_out.gnt && !busy_reg && !reset_in;
        fill_rsp_out.rvalid <= busy_reg;
        fill_rsp_out.rdata <= busy_reg ? word_at(addr_reg) : ~fill_rsp_out.rdata;
        addr_reg <= busy_reg ? addr_reg + 32'h4 : fill_req_in.addr;
        busy_reg <= !reset_in && (busy_reg ? beat_reg != 3'h7 : fill_rsp_out.gnt);
        beat_reg <= busy_reg ? beat_reg + 3'h1 : 3'h0;
    end
endmodule
`default_nettype wire

// ### verif/fetch_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fetch_chk
    import fetch_pkg::*;
(
    // Watched ports.
    input wire logic           clk_in,
    input wire logic           reset_in,
    input wire redirect_type   redirect_in,
    input wire logic           dec_ready_in,
    input wire slot_type [1:0] issue_out,
    input wire fill_req_type   fill_req_out,
    input wire fill_rsp_type   fill_rsp_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_grant;
        fill_req_out.req && fill_rsp_in.gnt;
    endsequence
    AST_PAIR: assert property (issue_out[1].valid |-> issue_out[0].valid &&
        !issue_out[0].pred_taken && issue_out[1].pc == issue_out[0].pc + 32'h4) else $error("pair");
    AST_HOLD: assert property (issue_out[0].valid && !dec_ready_in && !redirect_in.valid
        |=> $stable(issue_out)) else $error("hold");
    AST_FLUSH: assert property (redirect_in.valid |=> !issue_out[0].valid)
        else $error("flush");
    AST_TGT: assert property (issue_out[0].valid && !issue_out[0].pred_taken
        |-> issue_out[0].pred_target == 32'h0) else $error("target");
    AST_RST: assert property ($fell(reset_in) |-> !issue_out[0].valid && !fill_req_out.req)
        else $error("reset");
    AST_ALIGN: assert property (fill_req_out.req |-> fill_req_out.addr[4:0] == 5'h0)
        else $error("align");
    AST_WAIT: assert property (fill_req_out.req && !fill_rsp_in.gnt |=> fill_req_out.req)
        else $error("wait");
    AST_DROP: assert property (s_grant |=> !fill_req_out.req [*8])
        else $error("drop");
endmodule
bind instruction_fetch_unit fetch_chk i_fetch_chk (.clk_in(clk_in), .reset_in(reset_in),
    .redirect_in(redirect_in), .dec_ready_in(dec_ready_in), .issue_out(issue_out),
    .fill_req_out(fill_req_out), .fill_rsp_in(fill_rsp_in));
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import fetch_pkg::*;
;
    logic           clk_in = 1'b0;
    logic           reset_in = 1'b1;
    logic           slow = 1'b0;
    logic           ret_seen;
    logic           dec_ready;
    redirect_type   redirect_in = '0;
    slot_type [1:0] issue_out;
    addr_type       vaddr;
    addr_type       exp_pc;
    fill_req_type   fill_req;
    fill_rsp_type   fill_rsp;
    int             fails = 0;
    int             check_count = 0;
    int             seen = 0;
    int             cycles = 0;
    instruction_fetch_unit i_instruction_fetch_unit (.clk_in(clk_in), .reset_in(reset_in),
        .redirect_in(redirect_in), .resolve_in('0), .dec_ready_in(dec_ready),
        .issue_out(issue_out), .fetch_vaddr_out(vaddr), .fetch_ptag_in(vaddr[31:12]),
        .fill_req_out(fill_req), .fill_rsp_in(fill_rsp));
    exec_model i_exec_model (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
        .fill_req_in(fill_req), .fill_rsp_out(fill_rsp), .dec_ready_out(dec_ready));
    // Clock and a watchdog on the run length.
    initial
        forever #5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            end_of_test();
        end
    end
    // Compares one word and counts the outcome.
    task automatic check(input string name, input addr_type exp, input addr_type got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Judges one delivered slot and works out the next address in program order.
    task automatic take(input slot_type s);
        logic     tk;
        addr_type nxt;
        tk = exp_pc == 32'h24 || exp_pc == 32'h34 || (exp_pc == 32'h40 && !ret_seen);
        nxt = exp_pc == 32'h24 ? 32'h34 : exp_pc == 32'h34 ? 32'h40 : tk ? 32'h38 : exp_pc + 32'h4;
        ret_seen = ret_seen || exp_pc == 32'h40;
        check("pc", exp_pc, s.pc);
        check("insn", i_exec_model.word_at(exp_pc), s.insn);
        check("taken", {31'h0, tk}, {31'h0, s.pred_taken});
        check("target", tk ? nxt : 32'h0, s.pred_target);
        exp_pc = nxt;
        seen++;
    endtask
    // Restarts at address zero and follows twenty handoffs.
    task automatic run_trace(input logic pace);
        seen = 0;
        ret_seen = 1'b0;
        exp_pc = 32'h0;
        slow = pace;
        redirect_in = {1'b1, 32'h0};
        @(posedge clk_in);
        #1;
        redirect_in = '0;
        while (seen < 20)
        begin
            @(negedge clk_in);
            if (dec_ready && issue_out[0].valid === 1'b1)
                take(issue_out[0]);
            if (dec_ready && issue_out[1].valid === 1'b1)
                take(issue_out[1]);
        end
        @(posedge clk_in);
        #1;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        run_trace(1'b0);
        run_trace(1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
